// >>> iob_nco.sv
// Phase-accumulator model of one trimmed oscillator, one pulse per cycle
`timescale 1ns/1ps
`default_nettype none
module iob_nco
  import iob_pkg::*;
(
  input  wire logic                           clk,     // System clock
  input  wire logic                           rst_n,   // Synchronous reset
  input  wire logic                           run,     // Oscillator enabled
  input  wire logic [iob_pkg::IOB_ACC_W-1:0]  inc,     // Phase step per clock
  output logic                                tick     // One pulse per osc period
);

  logic [IOB_ACC_W-1:0] phase_q;
  logic [IOB_ACC_W:0]   sum;

  assign sum = {1'b0, phase_q} + {1'b0, inc};

  // Phase restarts when stopped so a restart begins a full period
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      phase_q <= '0;
      tick    <= 1'b0;
    end else begin
      phase_q <= sum[IOB_ACC_W-1:0];
      tick    <= sum[IOB_ACC_W];
    end
  end

endmodule // iob_nco
`default_nettype wire

// >>> iob_osc_ctrl.sv
// Internal oscillator block control: sources, postscaler, trim and pin modes
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module iob_osc_ctrl
  import iob_pkg::*;
(
  input  wire logic                           clk,            // 200 MHz system clock
  input  wire logic                           rst_n,          // Synchronous reset
  // Wishbone classic slave
  input  wire logic                           wb_cyc_i,       // Cycle
  input  wire logic                           wb_stb_i,       // Strobe
  input  wire logic                           wb_we_i,        // Write enable
  input  wire logic [iob_pkg::IOB_WB_AW-1:0]  wb_adr_i,       // Byte address
  input  wire logic [3:0]                     wb_sel_i,       // Byte lanes
  input  wire logic [iob_pkg::IOB_WB_DW-1:0]  wb_dat_i,       // Write data
  output logic [iob_pkg::IOB_WB_DW-1:0]       wb_dat_o,       // Read data
  output logic                                wb_ack_o,       // Acknowledge
  // Clock configuration
  input  wire iob_pkg::iob_mode_t             oscMode,        // Pin mode strap
  input  wire logic                           useInternal,    // Block drives system clock
  input  wire logic                           powerUpTmrEn,   // Power-up timer enabled
  input  wire logic                           watchdogEn,     // Watchdog timer enabled
  input  wire logic                           twoSpeedEn,     // Two-speed start-up enabled
  input  wire logic                           failSafeEn,     // Fail-safe monitor enabled
  output logic                                sysTick,        // Block output clock pulse
  output logic                                slowTick,       // Slow RC pulse for watchdog
  output logic                                slowRcEnable,   // Slow RC running
  // Port bits that borrow the oscillator pins
  input  wire logic                           portBit7Out,    // Port bit seven drive value
  input  wire logic                           portBit7TrisIn, // Port bit seven is input
  input  wire logic                           portBit6Out,    // Port bit six drive value
  input  wire logic                           portBit6TrisIn, // Port bit six is input
  output logic                                portBit7In,     // Port bit seven pin level
  output logic                                portBit6In,     // Port bit six pin level
  // Oscillator pins
  input  wire logic                           oscPinOneIn,    // Pin one level
  output logic                                oscPinOneOut,   // Pin one drive value
  output logic                                oscPinOneOe_n,  // Pin one driven when low
  input  wire logic                           oscPinTwoIn,    // Pin two level
  output logic                                oscPinTwoOut,   // Pin two drive value
  output logic                                oscPinTwoOe_n   // Pin two driven when low
);

  // Signed trim scaled to a phase step; a full-range product needs 33 bits
  function automatic logic [IOB_ACC_W-1:0] trimInc(input logic [IOB_ACC_W-1:0] base,
                                                   input logic [IOB_TRIM_W-1:0] trim);
    logic [8:0]  scale;
    logic [32:0] prod;
    scale = IOB_TRIM_UNITY + {{3{trim[IOB_TRIM_W-1]}}, trim};
    prod  = {9'h000, base} * {24'h000000, scale};
    return prod[IOB_ACC_W+IOB_TRIM_SHIFT-1:IOB_TRIM_SHIFT];
  endfunction

  function automatic logic regHit(input logic [IOB_WB_AW-1:0] adr,
                                  input logic [7:0] ofs);
    return adr[IOB_WB_AW-1:2] == ofs[7:2];
  endfunction

  logic                  ackD;
  logic                  wrStb;
  logic [IOB_TRIM_W-1:0] trim_q;
  logic [IOB_FSEL_W-1:0] fsel_q;
  logic [IOB_TRIM_W-1:0] slowTrim_q;
  logic [IOB_TRIM_W-1:0] fastTrim_q;
  logic [IOB_STEP_W-1:0] step_q;
  logic                  fastTick;
  logic                  slowOsc;
  logic                  slowEnD;
  logic [IOB_PS_TAPS-1:0] psCnt_q;
  logic [IOB_PS_TAPS:1]  tapHit;
  logic                  sysTickD;
  logic [1:0]            quarter_q;
  logic [IOB_WB_DW-1:0]  rdD;

  // Bus slave: one wait state, ack for every address, unmapped reads zero
  assign ackD  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wrStb = ackD & wb_we_i & wb_sel_i[0];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= ackD;
    end
  end

  always_comb begin
    rdD = '0;
    if (regHit(wb_adr_i, IOB_TRIM_OFS)) begin
      rdD[IOB_TRIM_LSB +: IOB_TRIM_W] = trim_q;
    end else if (regHit(wb_adr_i, IOB_CTRL_OFS)) begin
      rdD[IOB_FSEL_LSB +: IOB_FSEL_W] = fsel_q;
    end else if (regHit(wb_adr_i, IOB_STATUS_OFS)) begin
      rdD[IOB_ST_SLOWEN]  = slowRcEnable;
      rdD[IOB_ST_SLOWSRC] = (fsel_q == IOB_FSEL_SLOW);
    end
  end

  // Trim readback holds only what software wrote, never the settling state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_dat_o <= '0;
    end else if (ackD && !wb_we_i) begin
      wb_dat_o <= rdD;
    end
  end

  // Trim register; bits 7:6 have no storage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trim_q <= IOB_TRIM_RST;
    end else if (wrStb && regHit(wb_adr_i, IOB_TRIM_OFS)) begin
      trim_q <= wb_dat_i[IOB_TRIM_LSB +: IOB_TRIM_W];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fsel_q <= IOB_FSEL_RST;
    end else if (wrStb && regHit(wb_adr_i, IOB_CTRL_OFS)) begin
      fsel_q <= wb_dat_i[IOB_FSEL_LSB +: IOB_FSEL_W];
    end
  end

  // Slow source takes the new trim at its next own edge, well inside 8 cycles
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slowTrim_q <= IOB_TRIM_RST;
    end else if (slowOsc || !slowRcEnable) begin
      slowTrim_q <= trim_q;
    end
  end

  // Fast source walks one trim step per interval, so the worst swing fits 1 ms
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      step_q     <= '0;
      fastTrim_q <= IOB_TRIM_RST;
    end else if (fastTrim_q == trim_q) begin
      step_q     <= '0;
    end else if (step_q == IOB_STEP_W'(IOB_FAST_STEP_CYC - 1)) begin
      step_q     <= '0;
      if ($signed(fastTrim_q) < $signed(trim_q)) begin
        fastTrim_q <= fastTrim_q + 6'h01;
      end else begin
        fastTrim_q <= fastTrim_q - 6'h01;
      end
    end else begin
      step_q     <= step_q + 12'h001;
    end
  end

  // Slow source enable
  assign slowEnD = (useInternal && fsel_q == IOB_FSEL_SLOW) ||
                   powerUpTmrEn || watchdogEn || twoSpeedEn || failSafeEn;

  // Registered so the oscillator never sees a glitch from the feature inputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slowRcEnable <= 1'b0;
    end else begin
      slowRcEnable <= slowEnD;
    end
  end

  // The 8 MHz source always runs; its step carries the trim
  iob_nco u_fast (
    .clk   (clk),
    .rst_n (rst_n),
    .run   (1'b1),
    .inc   (trimInc(IOB_FAST_INC, fastTrim_q)),
    .tick  (fastTick)
  );

  iob_nco u_slow (
    .clk   (clk),
    .rst_n (rst_n),
    .run   (slowRcEnable),
    .inc   (trimInc(IOB_SLOW_INC, slowTrim_q)),
    .tick  (slowOsc)
  );

  // Postscaler: tap k divides the fast source by 2**k
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      psCnt_q <= '0;
    end else if (fastTick) begin
      psCnt_q <= psCnt_q + 6'h01;
    end
  end

  for (genvar k = 1; k <= IOB_PS_TAPS; k++) begin : g_tap
    assign tapHit[k] = fastTick & (&psCnt_q[k-1:0]);
  end

  // Selection is purely from the live field, so a write changes the next pulse
  always_comb begin
    case (fsel_q)
      3'h0:    sysTickD = slowOsc;
      3'h1:    sysTickD = tapHit[6];
      3'h2:    sysTickD = tapHit[5];
      3'h3:    sysTickD = tapHit[4];
      3'h4:    sysTickD = tapHit[3];
      3'h5:    sysTickD = tapHit[2];
      3'h6:    sysTickD = tapHit[1];
      3'h7:    sysTickD = fastTick;
      default: sysTickD = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sysTick <= 1'b0;
    end else begin
      sysTick <= sysTickD;
    end
  end

  // Watchdog timebase follows the retrimmed slow source directly
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slowTick <= 1'b0;
    end else begin
      slowTick <= slowOsc;
    end
  end

  // Clock-out divider: pin level flips every second system pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      quarter_q <= '0;
    end else if (sysTickD) begin
      quarter_q <= quarter_q + 2'h1;
    end
  end

  // Pin one is port bit seven in both internal modes and released otherwise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oscPinOneOut  <= 1'b0;
      oscPinOneOe_n <= 1'b1;
      portBit7In    <= 1'b0;
    end else begin
      case (oscMode)
        IOB_MODE_CLKOUT, IOB_MODE_ALLIO: begin
          oscPinOneOut  <= portBit7Out;
          oscPinOneOe_n <= portBit7TrisIn;
          portBit7In    <= oscPinOneIn;
        end
        default: begin
          oscPinOneOut  <= 1'b0;
          oscPinOneOe_n <= 1'b1;
          portBit7In    <= 1'b0;
        end
      endcase
    end
  end

  // Pin two carries the clock or port bit six; a port bit reads zero while
  // the oscillator owns its pin, so stale pin levels never reach port reads
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oscPinTwoOut  <= 1'b0;
      oscPinTwoOe_n <= 1'b1;
      portBit6In    <= 1'b0;
    end else begin
      case (oscMode)
        IOB_MODE_CLKOUT: begin
          oscPinTwoOut  <= quarter_q[1];
          oscPinTwoOe_n <= 1'b0;
          portBit6In    <= 1'b0;
        end
        IOB_MODE_ALLIO: begin
          oscPinTwoOut  <= portBit6Out;
          oscPinTwoOe_n <= portBit6TrisIn;
          portBit6In    <= oscPinTwoIn;
        end
        default: begin
          oscPinTwoOut  <= 1'b0;
          oscPinTwoOe_n <= 1'b1;
          portBit6In    <= 1'b0;
        end
      endcase
    end
  end

endmodule // iob_osc_ctrl
`default_nettype wire

// >>> iob_osc_ctrl_assertions.sv
// Port checker for the internal oscillator block control
`timescale 1ns/1ps
`default_nettype none
module iob_osc_ctrl_assertions
  import iob_pkg::*;
(
  input wire logic               clk,            // Clock
  input wire logic               rst_n,          // Reset
  input wire logic               wb_cyc_i,       // Cycle
  input wire logic               wb_stb_i,       // Strobe
  input wire logic               wb_we_i,        // Write
  input wire logic               wb_ack_o,       // Ack
  input wire iob_pkg::iob_mode_t oscMode,        // Pin mode
  input wire logic               useInternal,    // Internal clock
  input wire logic               powerUpTmrEn,   // Feature
  input wire logic               watchdogEn,     // Feature
  input wire logic               twoSpeedEn,     // Feature
  input wire logic               failSafeEn,     // Feature
  input wire logic               slowTick,       // Slow pulse
  input wire logic               slowRcEnable,   // Slow on
  input wire logic               portBit7Out,    // Port drive
  input wire logic               portBit7TrisIn, // Port dir
  input wire logic               portBit6Out,    // Port drive
  input wire logic               portBit6TrisIn, // Port dir
  input wire logic               portBit7In,     // Port level
  input wire logic               portBit6In,     // Port level
  input wire logic               oscPinOneIn,    // Pin level
  input wire logic               oscPinOneOut,   // Pin drive
  input wire logic               oscPinOneOe_n,  // Pin enable
  input wire logic               oscPinTwoIn,    // Pin level
  input wire logic               oscPinTwoOut,   // Pin drive
  input wire logic               oscPinTwoOe_n   // Pin enable
);
  logic anyEn;
  assign anyEn = powerUpTmrEn || watchdogEn || twoSpeedEn || failSafeEn;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Guarded by the past reset so the first edge after release sees reset values
  property p_pin_one(iob_mode_t m);
    $past(rst_n) && $past(oscMode) == m |-> oscPinOneOut == $past(portBit7Out)
      && oscPinOneOe_n == $past(portBit7TrisIn) && portBit7In == $past(oscPinOneIn);
  endproperty
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged in one cycle");
  a_slow_feature: assert property (anyEn |=> slowRcEnable)
    else $error("slow source off while a feature needs it");
  a_slow_idle: assert property ($past(rst_n) && !$past(anyEn || useInternal)
    |-> !slowRcEnable)
    else $error("slow source on with nothing needing it");
  a_slow_stop: assert property (!slowRcEnable && $past(!slowRcEnable)
    && $past(!slowRcEnable, 2) |-> !slowTick)
    else $error("slow pulse while slow source is off");
  a_allio_pin_one: assert property (p_pin_one(IOB_MODE_ALLIO))
    else $error("pin one not mapped to port bit seven");
  a_clkout_pin_one: assert property (p_pin_one(IOB_MODE_CLKOUT))
    else $error("pin one not mapped to port bit seven");
  a_allio_pin_two: assert property ($past(rst_n) && $past(oscMode) == IOB_MODE_ALLIO
    |-> oscPinTwoOut == $past(portBit6Out) && oscPinTwoOe_n == $past(portBit6TrisIn)
    && portBit6In == $past(oscPinTwoIn))
    else $error("pin two not mapped to port bit six");
  a_clkout_pin_two: assert property ($past(rst_n) && $past(oscMode) == IOB_MODE_CLKOUT
    |-> !oscPinTwoOe_n && !portBit6In)
    else $error("pin two not driving the clock");
  a_other_release: assert property ($past(oscMode) == IOB_MODE_OTHER
    |-> oscPinOneOe_n && oscPinTwoOe_n)
    else $error("pins driven outside internal modes");
  c_write: cover property (wb_ack_o && wb_we_i);
  c_slow: cover property (slowTick);
  c_clkout: cover property ($rose(oscPinTwoOut));
endmodule // iob_osc_ctrl_assertions
bind iob_osc_ctrl iob_osc_ctrl_assertions i_chk (.clk, .rst_n, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_ack_o, .oscMode, .useInternal, .powerUpTmrEn, .watchdogEn, .twoSpeedEn,
  .failSafeEn, .slowTick, .slowRcEnable, .portBit7Out, .portBit7TrisIn, .portBit6Out,
  .portBit6TrisIn, .portBit7In, .portBit6In, .oscPinOneIn, .oscPinOneOut, .oscPinOneOe_n,
  .oscPinTwoIn, .oscPinTwoOut, .oscPinTwoOe_n);
`default_nettype wire

// >>> iob_pkg.sv
// Constants, register map and types for the internal oscillator block control
package iob_pkg;

  // Bus geometry
  localparam int IOB_WB_AW = 8;
  localparam int IOB_WB_DW = 32;

  // Register byte offsets
  localparam logic [7:0] IOB_TRIM_OFS   = 8'h90;
  localparam logic [7:0] IOB_CTRL_OFS   = 8'h94;
  localparam logic [7:0] IOB_STATUS_OFS = 8'h98;

  // Field layout
  localparam int IOB_TRIM_W       = 6;
  localparam int IOB_TRIM_LSB     = 0;
  localparam int IOB_FSEL_W       = 3;
  localparam int IOB_FSEL_LSB     = 4;
  localparam int IOB_ST_SLOWEN    = 0;
  localparam int IOB_ST_SLOWSRC   = 1;

  // Reset values
  localparam logic [5:0] IOB_TRIM_RST = 6'h00;
  localparam logic [2:0] IOB_FSEL_RST = 3'h0;

  // Frequency select codes
  localparam logic [2:0] IOB_FSEL_SLOW = 3'h0;
  localparam logic [2:0] IOB_FSEL_FAST = 3'h7;
  localparam int         IOB_PS_TAPS   = 6;

  // Clock and oscillator rates
  localparam longint IOB_CLK_HZ     = 200_000_000;
  localparam longint IOB_CLK_NS     = 5;
  localparam longint IOB_FAST_HZ    = 8_000_000;
  localparam longint IOB_SLOW_MHZ   = 31_250_000;
  localparam int     IOB_ACC_W      = 24;
  localparam longint IOB_ACC_SPAN   = 64'd1 << IOB_ACC_W;

  // Phase increments at the calibrated centre
  localparam logic [23:0] IOB_FAST_INC = 24'(IOB_FAST_HZ * IOB_ACC_SPAN / IOB_CLK_HZ);
  localparam logic [23:0] IOB_SLOW_INC =
    24'(IOB_SLOW_MHZ * IOB_ACC_SPAN / (IOB_CLK_HZ * 1000));

  // Trim scale: one step is 1/256, so -32 to +31 steps give -12.5 to +12.1 percent
  localparam int          IOB_TRIM_SHIFT = 8;
  localparam logic [8:0]  IOB_TRIM_UNITY = 9'h100;

  // Fast source settling: whole trim range walked in no more than 1 ms
  localparam longint IOB_FAST_SETTLE_NS = 1_000_000;
  localparam longint IOB_TRIM_SPAN      = 64;
  localparam int     IOB_FAST_STEP_CYC  =
    int'((IOB_FAST_SETTLE_NS / IOB_CLK_NS) / IOB_TRIM_SPAN);
  localparam int     IOB_STEP_W         = 12;

  // Oscillator pin modes
  typedef enum logic [1:0] {
    IOB_MODE_OTHER  = 2'b00,
    IOB_MODE_CLKOUT = 2'b01,
    IOB_MODE_ALLIO  = 2'b10
  } iob_mode_t;

endpackage

// >>> test_iob_osc_ctrl.sv
// Self-checking bench for the internal oscillator block control
`timescale 1ns/1ps
`default_nettype none
module test_iob_osc_ctrl;
  import iob_pkg::*;
  logic        clk = 0, rst_n = 0, cyc = 0, we = 0, ui = 0;
  logic        p7 = 0, t7 = 1, p6 = 0, t6 = 1, i1 = 0, i2 = 0;
  logic [7:0]  adr = 0;
  logic [3:0]  sel = 0, feat = 0;
  logic [31:0] dat = 0, rdat, rdo;
  logic        ack, sys, slw, sre, b7, b6, o1, e1, o2, e2;
  logic [2:0]  mon;
  iob_mode_t   mode = IOB_MODE_OTHER;
  int          errCount = 0, nCompared = 0, w, p;
  assign mon = {o2, slw, sys};
  always #2.5 clk = ~clk;
  iob_osc_ctrl i_dut (.clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack),
    .oscMode(mode), .useInternal(ui), .powerUpTmrEn(feat[0]), .watchdogEn(feat[1]),
    .twoSpeedEn(feat[2]), .failSafeEn(feat[3]), .sysTick(sys), .slowTick(slw),
    .slowRcEnable(sre), .portBit7Out(p7), .portBit7TrisIn(t7), .portBit6Out(p6),
    .portBit6TrisIn(t6), .portBit7In(b7), .portBit6In(b6), .oscPinOneIn(i1),
    .oscPinOneOut(o1), .oscPinOneOe_n(e1), .oscPinTwoIn(i2), .oscPinTwoOut(o2),
    .oscPinTwoOe_n(e2));
  task automatic final_report;
    $display("compared %0d, mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errCount++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Request held until the edge where ack is seen, then released
  task automatic bus(input logic wr_, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1;
    we <= wr_;
    adr <= a;
    dat <= d;
    sel <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      errCount++;
      final_report();
    end
    rdat = rdo;
    cyc <= 0;
    we <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1, a, d, 4'h1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(0, a, 32'h0, 4'hF);
    check(rdat, e);
  endtask
  // First rising pulse lands in w, spacing to the next one in p
  task automatic meas(input int k);
    logic q;
    q = 1;
    w = 0;
    p = 0;
    for (int n = 0; n < 20000 && p == 0; n++) begin
      @(posedge clk);
      if (mon[k] === 1'b1 && !q) begin
        if (w == 0) w = n + 1;
        else p = n + 1 - w;
      end
      q = (mon[k] === 1'b1);
    end
    if (p == 0) begin
      errCount++;
      final_report();
    end
  endtask
  function automatic logic [31:0] near(input int e, input int t);
    return 32'(p >= e - t && p <= e + t);
  endfunction
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    rd(IOB_TRIM_OFS, 32'h0);
    rd(IOB_CTRL_OFS, 32'h0);
    rd(IOB_STATUS_OFS, 32'h2);
    rd(8'hA0, 32'h0);
    for (int i = 0; i < 4; i++) begin
      feat <= 4'h1 << i;
      repeat (2) @(posedge clk);
      rd(IOB_STATUS_OFS, 32'h3);
      check(32'(sre), 32'h1);
    end
    feat <= 4'h0;
    ui <= 1;
    meas(0);
    check(near(6400, 1), 32'h1);
    for (int c = 1; c < 8; c++) begin
      wr(IOB_CTRL_OFS, 32'(c) << 4);
      meas(0);
      check(near(25 << (7 - c), 1), 32'h1);
      check(32'(w <= (25 << (7 - c)) + 1), 32'h1);
    end
    rd(IOB_STATUS_OFS, 32'h0);
    check(32'(sre), 32'h0);
    mode <= IOB_MODE_ALLIO;
    p7 <= 1;
    t7 <= 0;
    t6 <= 0;
    i2 <= 1;
    repeat (3) @(posedge clk);
    check(32'({o1, e1, o2, e2, b7, b6}), 32'h21);
    mode <= IOB_MODE_CLKOUT;
    t7 <= 1;
    i1 <= 1;
    repeat (3) @(posedge clk);
    check(32'({e1, e2, b7, b6}), 32'hA);
    meas(2);
    check(near(100, 2), 32'h1);
    mode <= IOB_MODE_OTHER;
    repeat (3) @(posedge clk);
    check(32'({e1, e2}), 32'h3);
    // Trim work last: the fast source slews slowly and would spoil the rate checks
    wr(IOB_CTRL_OFS, 32'h0);
    wr(IOB_TRIM_OFS, 32'hFF);
    rd(IOB_TRIM_OFS, 32'h3F);
    bus(1, IOB_TRIM_OFS, 32'h1F, 4'h0);
    rd(IOB_TRIM_OFS, 32'h3F);
    wr(IOB_TRIM_OFS, 32'h1F);
    meas(1);
    check(near(5708, 8), 32'h1);
    wr(IOB_TRIM_OFS, 32'h20);
    meas(1);
    check(near(7314, 8), 32'h1);
    rd(IOB_STATUS_OFS, 32'h3);
    final_report();
  end
endmodule // test_iob_osc_ctrl
`default_nettype wire
